// File: rtl/tx_queue_pkg.sv
package tx_queue_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL         = 8'h00;
   localparam logic [7:0] OFF_STATE        = 8'h04;
   localparam logic [7:0] OFF_FREE         = 8'h08;
   localparam logic [7:0] OFF_PENDING      = 8'h0c;
   localparam logic [7:0] OFF_ENTRY_ID     = 8'h10;
   localparam logic [7:0] OFF_ENTRY_DLO    = 8'h14;
   localparam logic [7:0] OFF_ENTRY_DHI    = 8'h18;
   localparam logic [7:0] OFF_ENTRY_TLO    = 8'h1c;
   localparam logic [7:0] OFF_ENTRY_THI    = 8'h20;
   localparam logic [7:0] OFF_ENTRY_PUSH   = 8'h24;
   localparam logic [7:0] OFF_BATCH_COMMIT = 8'h28;
   localparam logic [7:0] OFF_BATCH_STATUS = 8'h2c;
   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h30;
   localparam logic [7:0] OFF_IRQ_EN       = 8'h34;
   localparam logic [7:0] OFF_IRQ_CLR      = 8'h38;

   // Control register bit positions
   localparam int CTRL_TIMING_BIT  = 0;
   localparam int CTRL_OPEN_BIT    = 1;
   localparam int CTRL_NOPACE_BIT  = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // Push register fields
   localparam int PUSH_KIND_LSB = 0;
   localparam int PUSH_DLC_LSB  = 8;

   // Interrupt status bit positions
   localparam int IRQ_OVF_BIT   = 0;
   localparam int IRQ_DONE_BIT  = 1;
   localparam int IRQ_SPACE_BIT = 2;
   localparam int IRQ_W         = 3;

   // Entry kinds
   localparam logic [7:0] KIND_DATA       = 8'h00;
   localparam logic [7:0] KIND_REMOTE     = 8'h01;
   localparam logic [7:0] KIND_START_TRIG = 8'h04;
   localparam logic [7:0] KIND_DELAY      = 8'h05;
   localparam logic [7:0] KIND_LIN_RESP   = 8'h10;
   localparam logic [7:0] KIND_LIN_HEADER = 8'h11;
   localparam logic [7:0] KIND_LIN_FULL   = 8'h12;

   // Queue geometry
   localparam int QAW        = 10;
   localparam int QDEPTH     = 1024;
   localparam int BATCH_MAX  = 512;

   // Batch status codes (signed 32-bit)
   localparam logic [31:0] STAT_OK         = 32'h0000_0000;
   localparam logic [31:0] STAT_ERR_OVF    = 32'hffff_ffff;
   localparam logic [31:0] STAT_ERR_BIG    = 32'hffff_fffe;
   localparam logic [31:0] STAT_WARN_EMPTY = 32'h0000_0001;

   // Timestamp tick: 100 ns units at a 4 ns clock
   localparam int TICK_NS     = 100;
   localparam int CLK_NS      = 4;
   localparam int TICK_CYCLES = TICK_NS / CLK_NS;

   // Transmit sequencer states
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_LOAD  = 6'h02,
      ST_PACE  = 6'h04,
      ST_DELAY = 6'h08,
      ST_TRIG  = 6'h10,
      ST_SEND  = 6'h20
   } tx_state_e;

endpackage : tx_queue_pkg

// File: rtl/timed_frame_transmit_queue.sv
`timescale 1ns/1ps

module timed_frame_transmit_queue
   import tx_queue_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Frame output toward the bus controller
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [7:0]       tx_entry_kind,
   output logic [31:0]      tx_id,
   output logic [3:0]       tx_dlc,
   output logic [63:0]      tx_data,
   // External start trigger pin
   input  wire logic        start_trigger,
   // Interrupt
   output logic             irq
);

   localparam int EW = 172;                 // Stored entry width

   // Control and holding registers
   logic [2:0]        ctrl;                 // Timing select, open, no-pacing
   logic [31:0]       hold_id;              // Staged arbitration id
   logic [63:0]       hold_data;            // Staged payload
   logic [63:0]       hold_ts;              // Staged timestamp or delay
   logic [IRQ_W-1:0]  irq_en;               // Interrupt enables
   logic [IRQ_W-1:0]  irq_stat;             // Sticky event bits

   // Queue storage and pointers
   logic [EW-1:0]     mem [QDEPTH];         // Entry array
   logic [QAW:0]      wr_ptr;               // Committed write pointer
   logic [QAW:0]      wr_tent;              // Tentative pointer of open batch
   logic [QAW:0]      rd_ptr;               // Read pointer
   logic [9:0]        batch_cnt;            // Entries pushed in open batch
   logic              batch_ovf;            // Open batch overran the queue
   logic              batch_big;            // Open batch exceeded its limit
   logic [31:0]       batch_status;         // Result of last commit
   logic [QAW:0]      q_count;              // Committed, not yet fetched
   logic [QAW:0]      free_count;           // Free entries
   logic [QAW:0]      pending_count;        // Queued plus in flight
   logic              space_ok;             // Batch space available
   logic              space_prev;           // For the rising edge event
   logic              final_done;           // Last frame has gone out

   // Sequencer
   tx_state_e         state;
   logic [7:0]        cur_kind;
   logic [31:0]       cur_id;
   logic [3:0]        cur_dlc;
   logic [63:0]       cur_data;
   logic [63:0]       cur_ts;
   logic [63:0]       prev_ts;              // Timestamp of last sent frame
   logic              first;                // Next frame goes without a gap
   logic [63:0]       gap;                  // Ticks to wait before sending
   logic [63:0]       elapsed;              // Ticks since last send or delay
   logic [4:0]        tick_div;             // 100 ns divider
   logic              tick;

   // Trigger synchroniser
   logic              trig_meta;
   logic              trig_sync;
   logic              trig_prev;
   logic              trig_rise;

   // Bus strobes and events
   logic              wr_en;
   logic              rd_setup;
   logic              push_req;
   logic              commit_req;
   logic              room;
   logic              commit_ok;
   logic              tx_fire;
   logic              done_evt;
   logic              abort;
   logic              paced;
   logic [31:0]       rd_val;
   logic              rd_hit;

   // Kinds that occupy the bus as frames
   function automatic logic is_bus_frame(input logic [7:0] k);
      return (k == KIND_DATA) || (k == KIND_REMOTE) ||
             (k == KIND_LIN_HEADER) || (k == KIND_LIN_FULL);
   endfunction : is_bus_frame

   // Address decode for a write strobe
   function automatic logic wr_at(input logic [7:0] off);
      return wr_en && (paddr == off);
   endfunction : wr_at

   // Zero-wait slave; writes land in the access cycle
   assign pready     = 1'b1;
   assign wr_en      = psel && penable && pwrite;
   assign rd_setup   = psel && !penable && !pwrite;
   assign push_req   = wr_at(OFF_ENTRY_PUSH);
   assign commit_req = wr_at(OFF_BATCH_COMMIT);
   assign abort      = !ctrl[CTRL_OPEN_BIT];

   // Occupancy; a batch in progress is invisible until committed
   assign q_count       = wr_ptr - rd_ptr;
   assign free_count    = (QAW+1)'(QDEPTH) - q_count;
   assign pending_count = q_count + (QAW+1)'(state != ST_IDLE);
   assign space_ok      = free_count >= (QAW+1)'(BATCH_MAX);
   assign room = ({1'b0, q_count} + 12'(batch_cnt)) < 12'(QDEPTH);
   // Success needs no wait for the bus: pointers just move
   assign commit_ok = commit_req && !batch_ovf && !batch_big && (batch_cnt != 10'h000);
   assign tx_fire   = tx_valid && tx_ready;
   assign done_evt  = tx_fire && (q_count == '0);
   // Pacing only for bus frames, mode 1, and on pacing variants
   assign paced = ctrl[CTRL_TIMING_BIT] && !ctrl[CTRL_NOPACE_BIT]
                  && is_bus_frame(cur_kind);

   // Read mux
   always_comb begin
      rd_hit = 1'b1;
      unique case (paddr)
         OFF_CTRL:         rd_val = {29'h0, ctrl};
         OFF_STATE:        rd_val = {29'h0, state != ST_IDLE, final_done, space_ok};
         OFF_FREE:         rd_val = 32'(free_count);
         OFF_PENDING:      rd_val = 32'(pending_count);
         OFF_ENTRY_ID:     rd_val = hold_id;
         OFF_ENTRY_DLO:    rd_val = hold_data[31:0];
         OFF_ENTRY_DHI:    rd_val = hold_data[63:32];
         OFF_ENTRY_TLO:    rd_val = hold_ts[31:0];
         OFF_ENTRY_THI:    rd_val = hold_ts[63:32];
         OFF_BATCH_STATUS: rd_val = batch_status;
         OFF_IRQ_STATUS:   rd_val = {29'h0, irq_stat};
         OFF_IRQ_EN:       rd_val = {29'h0, irq_en};
         OFF_ENTRY_PUSH, OFF_BATCH_COMMIT, OFF_IRQ_CLR: rd_val = 32'h0;
         default: begin
            // Unmapped addresses answer with an error
            rd_val = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= rd_setup ? rd_val : 32'h0;
         pslverr <= !rd_hit;
      end
   end

   // Software-written control and holding registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl      <= CTRL_RESET;
         hold_id   <= 32'h0;
         hold_data <= 64'h0;
         hold_ts   <= 64'h0;
         irq_en    <= '0;
      end else begin
         if (wr_at(OFF_CTRL)) ctrl <= pwdata[2:0];
         if (wr_at(OFF_ENTRY_ID)) hold_id <= pwdata;
         if (wr_at(OFF_ENTRY_DLO)) hold_data[31:0] <= pwdata;
         if (wr_at(OFF_ENTRY_DHI)) hold_data[63:32] <= pwdata;
         if (wr_at(OFF_ENTRY_TLO)) hold_ts[31:0] <= pwdata;
         if (wr_at(OFF_ENTRY_THI)) hold_ts[63:32] <= pwdata;
         if (wr_at(OFF_IRQ_EN)) irq_en <= pwdata[IRQ_W-1:0];
      end
   end

   // Entry storage; no reset so it maps onto RAM
   always_ff @(posedge pclk) begin
      if (push_req && !abort && room && (batch_cnt != 10'(BATCH_MAX)))
         mem[wr_tent[QAW-1:0]] <= {pwdata[PUSH_KIND_LSB +: 8], pwdata[PUSH_DLC_LSB +: 4],
                                   hold_id, hold_data, hold_ts};
   end

   // Batch assembly: entries go in behind a tentative pointer, so a
   // rejected batch is undone by rewinding it with nothing to copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr       <= '0;
         wr_tent      <= '0;
         batch_cnt    <= 10'h000;
         batch_ovf    <= 1'b0;
         batch_big    <= 1'b0;
         batch_status <= STAT_OK;
      end else if (abort) begin
         // Closing discards both the open batch and the queue
         wr_tent   <= wr_ptr;
         batch_cnt <= 10'h000;
         batch_ovf <= 1'b0;
         batch_big <= 1'b0;
      end else if (commit_req) begin
         batch_cnt <= 10'h000;
         batch_ovf <= 1'b0;
         batch_big <= 1'b0;
         if (batch_big) begin
            wr_tent      <= wr_ptr;
            batch_status <= STAT_ERR_BIG;
         end else if (batch_ovf) begin
            wr_tent      <= wr_ptr;
            batch_status <= STAT_ERR_OVF;
         end else if (batch_cnt == 10'h000) begin
            batch_status <= STAT_WARN_EMPTY;
         end else begin
            wr_ptr       <= wr_tent;
            batch_status <= STAT_OK;
         end
      end else if (push_req) begin
         if (batch_cnt == 10'(BATCH_MAX)) begin
            batch_big <= 1'b1;
         end else if (!room) begin
            batch_ovf <= 1'b1;
         end else begin
            wr_tent   <= wr_tent + 1'b1;
            batch_cnt <= batch_cnt + 10'h001;
         end
      end
   end

   // 100 ns tick and elapsed time since the last reference point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_div <= 5'h00;
         elapsed  <= 64'h0;
      end else begin
         tick_div <= tick ? 5'h00 : tick_div + 5'h01;
         // Paced gaps count from the hand-off; only a delay entry restarts here
         if (tx_fire || ((state == ST_LOAD) && (cur_kind == KIND_DELAY)))
            elapsed <= 64'h0;
         else if (tick && (elapsed != '1))
            elapsed <= elapsed + 64'h1;
      end
   end
   assign tick = (tick_div == 5'(TICK_CYCLES - 1));

   // Trigger pin synchroniser and edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end else begin
         trig_meta <= start_trigger;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end
   assign trig_rise = trig_sync && !trig_prev;

   // Transmit sequencer: one entry at a time from the read pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= ST_IDLE;
         rd_ptr        <= '0;
         cur_kind      <= 8'h00;
         cur_id        <= 32'h0;
         cur_dlc       <= 4'h0;
         cur_data      <= 64'h0;
         cur_ts        <= 64'h0;
         prev_ts       <= 64'h0;
         gap           <= 64'h0;
         first         <= 1'b1;
         tx_valid      <= 1'b0;
         tx_entry_kind <= 8'h00;
         tx_id         <= 32'h0;
         tx_dlc        <= 4'h0;
         tx_data       <= 64'h0;
      end else if (abort) begin
         // Close drops whatever is left
         state    <= ST_IDLE;
         rd_ptr   <= wr_ptr;
         tx_valid <= 1'b0;
         first    <= 1'b1;
      end else begin
         // A batch landing on an idle, empty queue starts fresh
         if (commit_ok && (q_count == '0) && (state == ST_IDLE))
            first <= 1'b1;
         unique case (state)
            ST_IDLE: begin
               if (q_count != '0) begin
                  // Oldest entry first
                  {cur_kind, cur_dlc, cur_id, cur_data, cur_ts} <= mem[rd_ptr[QAW-1:0]];
                  rd_ptr <= rd_ptr + 1'b1;
                  state  <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               gap <= cur_ts - prev_ts;
               if (cur_kind == KIND_DELAY)
                  state <= ST_DELAY;
               else if (cur_kind == KIND_START_TRIG)
                  state <= ST_TRIG;
               else if (paced && !first && (cur_ts >= prev_ts))
                  state <= ST_PACE;
               else begin
                  // First, immediate, or timestamp went backwards
                  state <= ST_SEND;
                  tx_valid <= 1'b1;
               end
               tx_entry_kind <= cur_kind;
               tx_id         <= cur_id;
               tx_dlc        <= cur_dlc;
               tx_data       <= cur_data;
            end
            ST_PACE: begin
               // Gap counts from the previous frame's hand-off
               if (elapsed >= gap) begin
                  state    <= ST_SEND;
                  tx_valid <= 1'b1;
               end
            end
            ST_DELAY: begin
               // Delay entry carries its length in the timestamp field
               if (elapsed >= cur_ts) begin
                  state <= ST_IDLE;
                  first <= 1'b1;
               end
            end
            ST_TRIG: begin
               if (trig_rise) begin
                  state <= ST_IDLE;
                  first <= 1'b1;
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  tx_valid <= 1'b0;
                  state    <= ST_IDLE;
                  // A backward stamp restarts the timeline here
                  prev_ts  <= cur_ts;
                  first    <= 1'b0;
               end
            end
         endcase
      end
   end

   // Sticky events, status flags and the interrupt line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat   <= '0;
         space_prev <= 1'b1;
         final_done <= 1'b0;
      end else begin
         space_prev <= space_ok;
         // Commit clears, but a completion in the same cycle wins
         if (done_evt)
            final_done <= 1'b1;
         else if (commit_ok)
            final_done <= 1'b0;
         // Set beats clear for every bit
         irq_stat <= (irq_stat & ~(wr_at(OFF_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0))
                     | {space_ok && !space_prev,
                        done_evt,
                        commit_req && batch_ovf && !abort};
      end
   end
   assign irq = |(irq_stat & irq_en);

   // Checks
   sequence s_frame_loaded;
      (state == ST_LOAD) && is_bus_frame(cur_kind);
   endsequence

   sequence s_goes_now;
      (state == ST_SEND) && tx_valid;
   endsequence

   a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_at(OFF_CTRL) |=> ctrl[CTRL_TIMING_BIT] == $past(pwdata[0]))
      else $error("timing select not taken from write");

   a_commit_nowait: assert property (@(posedge pclk) disable iff (!presetn)
      commit_ok && !abort |=> wr_ptr == $past(wr_tent) && batch_status == STAT_OK)
      else $error("good commit did not publish entries at once");

   a_gap_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state == ST_PACE) && (elapsed < gap) && !abort |=> state == ST_PACE && !tx_valid)
      else $error("paced frame left before its gap");

   a_backward_now: assert property (@(posedge pclk) disable iff (!presetn)
      s_frame_loaded and (!first && cur_ts < prev_ts && !abort) |=> s_goes_now)
      else $error("backward timestamp was delayed");

   a_first_now: assert property (@(posedge pclk) disable iff (!presetn)
      s_frame_loaded and (first && !abort) |=> s_goes_now)
      else $error("first frame was delayed");

   a_immediate_now: assert property (@(posedge pclk) disable iff (!presetn)
      s_frame_loaded and (!paced && !abort) |=> s_goes_now)
      else $error("immediate frame was delayed");

   a_delay_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state == ST_DELAY) |-> !tx_valid)
      else $error("frame sent during delay entry");

   a_ovf_reject: assert property (@(posedge pclk) disable iff (!presetn)
      commit_req && batch_ovf && !batch_big && !abort
      |=> wr_ptr == $past(wr_ptr) && wr_tent == wr_ptr && batch_status == STAT_ERR_OVF)
      else $error("overflowed batch partly accepted");

   a_space_flag: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(space_ok) |-> free_count >= 11'(BATCH_MAX) ##1 irq_stat[IRQ_SPACE_BIT])
      else $error("space event missing");

   a_free_count: assert property (@(posedge pclk) disable iff (!presetn)
      (free_count + q_count) == 11'(QDEPTH) && free_count <= 11'(QDEPTH))
      else $error("free count inconsistent");

   a_final_done: assert property (@(posedge pclk) disable iff (!presetn)
      done_evt && !abort |=> final_done ##1 (final_done || $past(commit_ok)))
      else $error("final transmit done not raised");

   a_close_abort: assert property (@(posedge pclk) disable iff (!presetn)
      wr_at(OFF_CTRL) && !pwdata[CTRL_OPEN_BIT] |=> ##1 pending_count == '0 && !tx_valid)
      else $error("close left entries pending");

   a_status_warn: assert property (@(posedge pclk) disable iff (!presetn)
      commit_req && !abort && batch_cnt == 10'h000 && !batch_ovf && !batch_big
      |=> batch_status == STAT_WARN_EMPTY)
      else $error("empty commit gave no warning");

   a_nopace_now: assert property (@(posedge pclk) disable iff (!presetn)
      s_frame_loaded and (ctrl[CTRL_NOPACE_BIT] && !abort) |=> s_goes_now)
      else $error("no-pacing variant delayed a frame");

endmodule : timed_frame_transmit_queue

// File: dv/bus_node_model.sv
`timescale 1ns/1ps
// Bus controller stand-in; stalls at random
module bus_node_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Frame port
   input  wire logic        tx_valid,
   input  wire logic [31:0] tx_id,
   output logic             tx_ready
);
   logic [31:0] got[$];  // Ids in arrival order
   int          at[$];   // Cycle of each handoff
   int          cyc;     // Cycle count
   logic [7:0]  lf;      // Stall pattern
   // Short stalls keep gap checks meaningful
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf <= 8'h5b;
         cyc <= 0;
         tx_ready <= 1'b0;
      end else begin
         cyc <= cyc + 1;
         lf <= {lf[6:0], lf[7] ^ lf[5]};
         tx_ready <= lf[0] | lf[1];
         if (tx_valid && tx_ready) begin
            got.push_back(tx_id);
            at.push_back(cyc);
         end
      end
   end
endmodule : bus_node_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
// Random and corner traffic through the queue
module tb_top import tx_queue_pkg::*; ;
   // Bench signals
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic        pwrite = 0, start_trigger = 0, pready, pslverr;
   logic        tx_valid, tx_ready, irq, err;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, seed = 32'h7, ids[4];
   int          mismatches = 0, total_checks = 0, t0;
   always #2 pclk = ~pclk;
   timed_frame_transmit_queue u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_entry_kind(),
      .tx_id(), .tx_dlc(), .tx_data(), .start_trigger(start_trigger),
      .irq(irq));
   bus_node_model u_node (.pclk(pclk), .presetn(presetn),
      .tx_valid(tx_valid), .tx_id(u_dut.tx_id), .tx_ready(tx_ready));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   // Setup then access, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge so the next setup never reassigns in this step
      @(posedge pclk);
      if (n >= 50) begin
         mismatches++;
         test_done();
      end
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc
   task automatic push(input logic [31:0] id, input logic [31:0] ts);
      apb(1'b1, OFF_ENTRY_ID, id);
      apb(1'b1, OFF_ENTRY_DLO, xs());
      apb(1'b1, OFF_ENTRY_TLO, ts);
      apb(1'b1, OFF_ENTRY_PUSH, {20'h0, 4'h8, KIND_DATA});
   endtask : push
   // Bounded wait for n handoffs in total
   task automatic wait_n(input int n);
      for (int i = 0; i < 5000 && u_node.got.size() < n; i++) @(posedge pclk);
      // Let flags launched at the last hand-off settle
      @(posedge pclk);
      if (u_node.got.size() < n) begin
         mismatches++;
         test_done();
      end
   endtask : wait_n
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(OFF_CTRL, 32'h0);
      rdc(OFF_FREE, QDEPTH);
      rdc(OFF_STATE, 32'h1);
      apb(1'b0, 8'hfc, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, OFF_IRQ_EN, 32'h2);
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_BATCH_COMMIT, 32'h0);
      rdc(OFF_BATCH_STATUS, STAT_WARN_EMPTY);
      for (int i = 0; i < 4; i++) begin
         ids[i] = xs() & 32'h1fff_ffff;
         push(ids[i], xs());
      end
      apb(1'b1, OFF_BATCH_COMMIT, 32'h0);
      rdc(OFF_PENDING, 32'h4);
      rdc(OFF_BATCH_STATUS, STAT_OK);
      wait_n(4);
      for (int i = 0; i < 4; i++) chk(u_node.got[i], ids[i]);
      chk(irq, 1'b1);
      rdc(OFF_STATE, 32'h3);
      apb(1'b1, OFF_IRQ_CLR, 32'h2);
      apb(1'b0, OFF_IRQ_STATUS, 32'h0);
      chk({rd[1], irq}, 2'b00);
      // Paced: ts 0, 2, then backward 1, then a far one to abort
      apb(1'b1, OFF_CTRL, 32'h3);
      push(32'h11, 32'h0);
      push(32'h22, 32'h2);
      push(32'h33, 32'h1);
      push(32'h44, 32'h10000);
      apb(1'b1, OFF_BATCH_COMMIT, 32'h0);
      t0 = u_node.cyc;
      wait_n(7);
      chk(u_node.at[4] - t0 <= 12, 1'b1);
      chk((u_node.at[5] - u_node.at[4]) inside {[25:80]}, 1'b1);
      chk(u_node.at[6] - u_node.at[5] <= 10, 1'b1);
      rdc(OFF_PENDING, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h0);
      repeat (4) @(posedge pclk);
      rdc(OFF_PENDING, 32'h0);
      chk(u_node.got.size(), 7);
      // Trigger then delay entries hold back the frame behind them
      apb(1'b1, OFF_CTRL, 32'h2);
      apb(1'b1, OFF_ENTRY_TLO, 32'h4);
      apb(1'b1, OFF_ENTRY_PUSH, {24'h0, KIND_START_TRIG});
      apb(1'b1, OFF_ENTRY_PUSH, {24'h0, KIND_DELAY});
      push(32'h55, 32'h0);
      apb(1'b1, OFF_BATCH_COMMIT, 32'h0);
      repeat (40) @(posedge pclk);
      chk(u_node.got.size(), 7);
      start_trigger <= 1'b1;
      t0 = u_node.cyc;
      wait_n(8);
      chk(u_node.at[7] - t0 >= 75, 1'b1);
      chk(u_node.got[7], 32'h55);
      test_done();
   end
endmodule : tb_top
